// file: srass_spi_slave.sv
`timescale 1ns/1ps
`include "srass_map.svh"
module srass_spi_slave #(
  parameter int ADDR_W = `SRASS_ADDR_W
) (
  // core clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // spi link pins
  input  wire logic                  spi_clk,
  input  wire logic                  spi_sel_n,
  input  wire logic                  spi_mosi,
  output logic                       spi_miso,
  // configuration
  input  wire logic                  cfg_wr,
  input  wire srass_pkg::srass_cfg_t cfg_in,
  output srass_pkg::srass_cfg_t      cfg_out,
  input  wire logic                  multipurpose_io_one,
  // status
  output logic                       spi_path_active,
  output logic                       path_settling,
  output logic                       frame_active,
  // write notification
  output logic                       reg_wr_valid,
  output logic [ADDR_W-1:0]          reg_wr_addr,
  output logic [7:0]                 reg_wr_data,
  // core read port
  input  wire logic [ADDR_W-1:0]     core_rd_addr,
  output logic [7:0]                 core_rd_data
);

  //========================================
  // declarations
  //========================================
  srass_pkg::srass_cfg_t     cfg_ff;
  srass_pkg::srass_cfg_t     nxt_cfg_ff;
  logic                      mpio_s;
  logic                      frame_s;
  logic                      tgl_s;
  logic                      path_sel;
  logic                      path_ff;
  logic                      nxt_path_ff;
  logic [`SRASS_SETTLE_W-1:0] settle_ff;
  logic [`SRASS_SETTLE_W-1:0] nxt_settle_ff;
  logic                      settling_ff;
  logic                      nxt_settling_ff;
  logic                      frame_ff;
  logic                      tgl_d_ff;
  logic                      wr_valid_ff;
  logic                      nxt_wr_valid_ff;
  logic [ADDR_W-1:0]         wr_addr_ff;
  logic [ADDR_W-1:0]         nxt_wr_addr_ff;
  logic [7:0]                wr_data_ff;
  logic [7:0]                nxt_wr_data_ff;

  logic                      link_clk;
  logic                      link_rst;
  logic [2:0]                lcfg_s;
  logic                      l_path_ok;
  logic                      l_rw_pol;
  logic                      l_len_en;
  srass_pkg::srass_phase_t   state_ff;
  srass_pkg::srass_phase_t   nxt_state_ff;
  logic [2:0]                bit_ff;
  logic [2:0]                nxt_bit_ff;
  logic [6:0]                rx_ff;
  logic [6:0]                nxt_rx_ff;
  logic                      rd_ff;
  logic                      nxt_rd_ff;
  logic                      burst_ff;
  logic                      nxt_burst_ff;
  logic [1:0]                page_ff;
  logic [1:0]                nxt_page_ff;
  logic [ADDR_W-1:0]         addr_ff;
  logic [ADDR_W-1:0]         nxt_addr_ff;
  logic [7:0]                rem_ff;
  logic [7:0]                nxt_rem_ff;
  logic                      len_mode_ff;
  logic                      nxt_len_mode_ff;
  logic                      load_ff;
  logic                      nxt_load_ff;
  logic [7:0]                rx_byte;
  logic                      byte_done;
  logic                      mem_we;
  logic                      last_byte;
  srass_pkg::srass_wr_evt_t  hold_ff;
  srass_pkg::srass_wr_evt_t  nxt_hold_ff;
  logic                      tgl_ff;
  logic                      nxt_tgl_ff;
  logic [7:0]                rd_data;
  logic                      miso_ff;
  logic                      nxt_miso_ff;
  logic [6:0]                tx_ff;
  logic [6:0]                nxt_tx_ff;

  //========================================
  // core domain: configuration and access path
  //========================================
  srass_sync #(.W(1)) u_mpio_sync (
    .clk (core_clk),
    .rst (rst),
    .d   (multipurpose_io_one),
    .q   (mpio_s)
  );

  // pin mode 0 with the select pin low gives the register path to spi
  assign path_sel = (cfg_ff.pin_function_mode == `SRASS_PINMODE_SPI) && !mpio_s;

  // next configuration, path and switch guard
  always_comb begin
    nxt_cfg_ff    = cfg_wr ? cfg_in : cfg_ff;
    nxt_path_ff   = path_sel;
    nxt_settle_ff = settle_ff;
    if (path_sel != path_ff) begin
      nxt_settle_ff = `SRASS_SETTLE_W'(`SRASS_SWITCH_WAIT_CYC);
    end else if (settle_ff != '0) begin
      nxt_settle_ff = settle_ff - 1'b1;
    end
    // registered copy keeps the status output glitch free
    nxt_settling_ff = (nxt_settle_ff != '0);
  end

  // length field enable comes out of reset set
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_ff    <= `SRASS_CFG_RST;
      path_ff   <= 1'b0;
      settle_ff <= '0;
      settling_ff <= 1'b0;
    end else begin
      cfg_ff    <= nxt_cfg_ff;
      path_ff   <= nxt_path_ff;
      settle_ff <= nxt_settle_ff;
      settling_ff <= nxt_settling_ff;
    end
  end

  //========================================
  // core domain: frame status and write notice
  //========================================
  srass_sync #(.W(2)) u_core_sync (
    .clk (core_clk),
    .rst (rst),
    .d   ({~spi_sel_n, tgl_ff}),
    .q   ({frame_s, tgl_s})
  );

  // hold words are stable long before the toggle reaches this side
  always_comb begin
    nxt_wr_valid_ff = tgl_s ^ tgl_d_ff;
    nxt_wr_addr_ff  = wr_addr_ff;
    nxt_wr_data_ff  = wr_data_ff;
    if (tgl_s ^ tgl_d_ff) begin
      nxt_wr_addr_ff = ADDR_W'(hold_ff.addr);
      nxt_wr_data_ff = hold_ff.data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frame_ff    <= 1'b0;
      tgl_d_ff    <= 1'b0;
      wr_valid_ff <= 1'b0;
      wr_addr_ff  <= '0;
      wr_data_ff  <= '0;
    end else begin
      frame_ff    <= frame_s;
      tgl_d_ff    <= tgl_s;
      wr_valid_ff <= nxt_wr_valid_ff;
      wr_addr_ff  <= nxt_wr_addr_ff;
      wr_data_ff  <= nxt_wr_data_ff;
    end
  end

  //========================================
  // link domain: clocking mode and framing
  //========================================
  // sample edge is the rising edge of link_clk in all four modes;
  // polarity and phase must only change while no frame is open
  assign link_clk = spi_clk ^ cfg_ff.clock_polarity_sel ^ cfg_ff.clock_phase_sel;
  // select high holds the whole frame logic in reset
  assign link_rst = rst | spi_sel_n;

  // path and mode levels are settled by the end of the control byte
  srass_sync #(.W(3)) u_link_sync (
    .clk (link_clk),
    .rst (link_rst),
    .d   ({path_ff, cfg_ff.rw_flag_polarity, cfg_ff.length_field_enable}),
    .q   (lcfg_s)
  );
  assign {l_path_ok, l_rw_pol, l_len_en} = lcfg_s;

  assign rx_byte   = {rx_ff, spi_mosi};
  assign byte_done = (bit_ff == 3'h7);
  assign last_byte = len_mode_ff ? (rem_ff == 8'h01) : !burst_ff;

  //========================================
  // link domain: byte sequencer
  //========================================
  always_comb begin
    nxt_state_ff    = state_ff;
    nxt_bit_ff      = bit_ff + 1'b1;
    nxt_rx_ff       = {rx_ff[5:0], spi_mosi};
    nxt_rd_ff       = rd_ff;
    nxt_burst_ff    = burst_ff;
    nxt_page_ff     = page_ff;
    nxt_addr_ff     = addr_ff;
    nxt_rem_ff      = rem_ff;
    nxt_len_mode_ff = len_mode_ff;
    nxt_load_ff     = 1'b0;
    mem_we          = 1'b0;
    unique case (state_ff)
      srass_pkg::SRASS_CTRL: begin
        if (byte_done) begin
          nxt_rd_ff    = rx_byte[`SRASS_CTRL_RW_BIT] ^ l_rw_pol;
          nxt_burst_ff = rx_byte[`SRASS_CTRL_BURST_BIT];
          nxt_page_ff  = rx_byte[`SRASS_CTRL_PAGE_HI:`SRASS_CTRL_PAGE_LO];
          // two-wire path owns the registers: sit out the frame
          nxt_state_ff = l_path_ok ? srass_pkg::SRASS_ADDR : srass_pkg::SRASS_WAIT;
        end
      end
      srass_pkg::SRASS_ADDR: begin
        if (byte_done) begin
          nxt_addr_ff     = ADDR_W'({page_ff, rx_byte});
          nxt_len_mode_ff = l_len_en;
          if (l_len_en) begin
            nxt_state_ff = srass_pkg::SRASS_LEN;
          end else begin
            nxt_state_ff = srass_pkg::SRASS_DATA;
            nxt_load_ff  = rd_ff;
          end
        end
      end
      srass_pkg::SRASS_LEN: begin
        if (byte_done) begin
          nxt_rem_ff = rx_byte;
          if (rx_byte == 8'h00) begin
            nxt_state_ff = srass_pkg::SRASS_WAIT;
          end else begin
            nxt_state_ff = srass_pkg::SRASS_DATA;
            nxt_load_ff  = rd_ff;
          end
        end
      end
      srass_pkg::SRASS_DATA: begin
        if (byte_done) begin
          // only a complete byte is committed; a cut one never reaches here
          mem_we      = !rd_ff;
          nxt_addr_ff = addr_ff + 1'b1;
          nxt_rem_ff  = rem_ff - 8'h01;
          if (last_byte) begin
            nxt_state_ff = srass_pkg::SRASS_WAIT;
          end else begin
            nxt_load_ff = rd_ff;
          end
        end
      end
      srass_pkg::SRASS_WAIT: begin
        nxt_bit_ff = bit_ff;
        nxt_rx_ff  = rx_ff;
      end
      default: begin
        nxt_state_ff = srass_pkg::SRASS_WAIT;
      end
    endcase
  end

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      state_ff    <= srass_pkg::SRASS_CTRL;
      bit_ff      <= '0;
      rx_ff       <= '0;
      rd_ff       <= 1'b0;
      burst_ff    <= 1'b0;
      page_ff     <= '0;
      addr_ff     <= '0;
      rem_ff      <= '0;
      len_mode_ff <= 1'b0;
      load_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state_ff;
      bit_ff      <= nxt_bit_ff;
      rx_ff       <= nxt_rx_ff;
      rd_ff       <= nxt_rd_ff;
      burst_ff    <= nxt_burst_ff;
      page_ff     <= nxt_page_ff;
      addr_ff     <= nxt_addr_ff;
      rem_ff      <= nxt_rem_ff;
      len_mode_ff <= nxt_len_mode_ff;
      load_ff     <= nxt_load_ff;
    end
  end

  //========================================
  // link domain: write notice toward the core
  //========================================
  // not reset by select, or a frame end would fake a toggle
  always_comb begin
    nxt_hold_ff = hold_ff;
    nxt_tgl_ff  = tgl_ff;
    if (mem_we) begin
      nxt_hold_ff.addr = 10'(addr_ff);
      nxt_hold_ff.data = rx_byte;
      nxt_tgl_ff       = !tgl_ff;
    end
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      hold_ff <= '0;
      tgl_ff  <= 1'b0;
    end else begin
      hold_ff <= nxt_hold_ff;
      tgl_ff  <= nxt_tgl_ff;
    end
  end

  //========================================
  // register space
  //========================================
  srass_regmem #(.AW(ADDR_W), .DW(`SRASS_BYTE_W)) u_regmem (
    .lnk_clk    (link_clk),
    .lnk_rst    (link_rst),
    .lnk_we     (mem_we),
    .lnk_waddr  (addr_ff),
    .lnk_wdata  (rx_byte),
    .lnk_raddr  (nxt_addr_ff),
    .lnk_rdata  (rd_data),
    .core_clk   (core_clk),
    .core_rst   (rst),
    .core_raddr (core_rd_addr),
    .core_rdata (core_rd_data)
  );

  //========================================
  // link domain: serial output on the launch edge
  //========================================
  // half a link period after the sample edge; idle and wait drive low
  always_comb begin
    nxt_miso_ff = 1'b0;
    nxt_tx_ff   = '0;
    if (load_ff) begin
      nxt_miso_ff = rd_data[7];
      nxt_tx_ff   = rd_data[6:0];
    end else if (state_ff == srass_pkg::SRASS_DATA && rd_ff) begin
      nxt_miso_ff = tx_ff[6];
      nxt_tx_ff   = {tx_ff[5:0], 1'b0};
    end
  end

  always_ff @(negedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      miso_ff <= 1'b0;
      tx_ff   <= '0;
    end else begin
      miso_ff <= nxt_miso_ff;
      tx_ff   <= nxt_tx_ff;
    end
  end

  //========================================
  // outputs
  //========================================
  assign spi_miso        = miso_ff;
  assign cfg_out         = cfg_ff;
  assign spi_path_active = path_ff;
  assign path_settling   = settling_ff;
  assign frame_active    = frame_ff;
  assign reg_wr_valid    = wr_valid_ff;
  assign reg_wr_addr     = wr_addr_ff;
  assign reg_wr_data     = wr_data_ff;

endmodule // srass_spi_slave

// file: srass_map.svh
`ifndef SRASS_MAP_SVH
`define SRASS_MAP_SVH
//========================================
// Summary of operation
// - four-wire byte-oriented slave, serial clock up to 26 MHz from the master.
// - transactions open on select low and close on select high.
// - control byte: bit 7 read/write, bit 6 burst flag, bits 1:0 page.
// - with polarity setting 0, flag 1 means read and flag 0 means write.
// - second byte is the 8-bit address; page gives the upper two of ten bits.
// - with length field enabled, third byte is the byte count, overriding burst flag.
// - length field enable resets to enabled.
// - write byte committed only after eight bits, then address increments.
// - single-byte transfer enters wait and ignores clocks until select rises.
// - counted burst writes successive addresses until count, then waits.
// - no length field with burst flag: write on until select rises.
// - select rising ends at once; whole bytes kept, partial byte dropped.
// - read shifts out addressed register, address increments after eight bits.
// - counted burst read stops at count; open burst runs until select rises.
// - serial data output driven low while select is high.
// - polarity and phase pick four modes; 0/0 idles low, samples rising.
// - pin mode 0: select pin low picks SPI, high picks the two-wire port.
//========================================

// register space
`define SRASS_ADDR_W          10
`define SRASS_BYTE_W          8

// control byte fields
`define SRASS_CTRL_RW_BIT     7
`define SRASS_CTRL_BURST_BIT  6
`define SRASS_CTRL_PAGE_HI    1
`define SRASS_CTRL_PAGE_LO    0

// configuration reset: only length field enable set
`define SRASS_CFG_RST         6'h01
`define SRASS_PINMODE_SPI     2'h0

// link rate and path switch guard
`define SRASS_LINK_MAX_MHZ    26
`define SRASS_SWITCH_WAIT_NS  50
`define SRASS_CORE_PERIOD_NS  10
`define SRASS_SWITCH_WAIT_CYC \
  ((`SRASS_SWITCH_WAIT_NS + `SRASS_CORE_PERIOD_NS - 1) / `SRASS_CORE_PERIOD_NS)
`define SRASS_SETTLE_W        4

`endif

// file: srass_pkg.sv
package srass_pkg;

  // configuration bits, length field enable in bit 0
  typedef struct packed {
    logic [1:0] pin_function_mode;
    logic       rw_flag_polarity;
    logic       clock_phase_sel;
    logic       clock_polarity_sel;
    logic       length_field_enable;
  } srass_cfg_t;

  // byte phases of a frame, gray along the usual path
  typedef enum logic [2:0] {
    SRASS_CTRL = 3'h0,
    SRASS_ADDR = 3'h1,
    SRASS_LEN  = 3'h3,
    SRASS_DATA = 3'h2,
    SRASS_WAIT = 3'h6
  } srass_phase_t;

  // one committed register write
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] data;
  } srass_wr_evt_t;

endpackage

// file: srass_sync.sv
`timescale 1ns/1ps
module srass_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  //========================================
  // two-stage level synchroniser
  //========================================
  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule // srass_sync

// file: srass_regmem.sv
`timescale 1ns/1ps
module srass_regmem #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  // link port
  input  wire logic          lnk_clk,
  input  wire logic          lnk_rst,
  input  wire logic          lnk_we,
  input  wire logic [AW-1:0] lnk_waddr,
  input  wire logic [DW-1:0] lnk_wdata,
  input  wire logic [AW-1:0] lnk_raddr,
  output logic      [DW-1:0] lnk_rdata,
  // core read port
  input  wire logic          core_clk,
  input  wire logic          core_rst,
  input  wire logic [AW-1:0] core_raddr,
  output logic      [DW-1:0] core_rdata
);

  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] lnk_rdata_ff;
  logic [DW-1:0] core_rdata_ff;

  //========================================
  // link side write and registered read
  //========================================
  always_ff @(posedge lnk_clk) begin
    if (lnk_we) begin
      mem[lnk_waddr] <= lnk_wdata;
    end
  end

  // read every edge so the next byte is ready before its first bit leaves
  always_ff @(posedge lnk_clk or posedge lnk_rst) begin
    if (lnk_rst) begin
      lnk_rdata_ff <= '0;
    end else begin
      lnk_rdata_ff <= mem[lnk_raddr];
    end
  end

  //========================================
  // core side registered read
  //========================================
  // may see a byte mid-update; core should read after the write notice
  always_ff @(posedge core_clk or posedge core_rst) begin
    if (core_rst) begin
      core_rdata_ff <= '0;
    end else begin
      core_rdata_ff <= mem[core_raddr];
    end
  end

  assign lnk_rdata  = lnk_rdata_ff;
  assign core_rdata = core_rdata_ff;

endmodule // srass_regmem

// file: srass_asserts.sv
`timescale 1ns/1ps
module srass_asserts #(
  parameter int ADDR_W = 10
) (
  // clock and reset
  input wire logic                  core_clk,
  input wire logic                  rst,
  // link pins
  input wire logic                  spi_sel_n,
  input wire logic                  spi_miso,
  // configuration and path
  input wire logic                  cfg_wr,
  input wire srass_pkg::srass_cfg_t cfg_in,
  input wire srass_pkg::srass_cfg_t cfg_out,
  input wire logic                  multipurpose_io_one,
  // status and write notices
  input wire logic                  spi_path_active,
  input wire logic                  path_settling,
  input wire logic                  frame_active,
  input wire logic                  reg_wr_valid,
  input wire logic [ADDR_W-1:0]     reg_wr_addr,
  input wire logic [7:0]            reg_wr_data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  //==========================================
  // write notices
  // byte spacing is about 12 core cycles, so one window holds one pair
  sequence s_two_writes;
    reg_wr_valid ##[2:16] reg_wr_valid;
  endsequence
  a_wr_addr_step: assert property (s_two_writes |-> reg_wr_addr == ADDR_W'($past(reg_wr_addr) + 1))
    else $error("write address did not step by one");
  a_wr_pulse_held: assert property (reg_wr_valid |=> (!reg_wr_valid && $stable(reg_wr_addr) && $stable(reg_wr_data)) [*8])
    else $error("write notice not a single held pulse");
  a_no_late_write: assert property (spi_sel_n [*8] |-> !reg_wr_valid)
    else $error("write notice long after frame end");

  //==========================================
  // link output and framing
  a_miso_idle_low: assert property (spi_sel_n |-> !spi_miso)
    else $error("miso not low while deselected");
  a_frame_track: assert property ($stable(spi_sel_n) [*4] |-> frame_active == !spi_sel_n)
    else $error("frame flag does not follow select");

  //==========================================
  // configuration and access path
  a_cfg_default: assert property ($fell(rst) |-> cfg_out == 6'h01)
    else $error("configuration reset value wrong");
  a_cfg_load: assert property (cfg_wr |=> cfg_out == $past(cfg_in))
    else $error("configuration not loaded");
  a_path_off: assert property ((multipurpose_io_one || cfg_out.pin_function_mode != 2'h0) [*4] |-> !spi_path_active)
    else $error("spi path active while not selected");
  a_path_on: assert property ((!multipurpose_io_one && cfg_out.pin_function_mode == 2'h0) [*4] |-> spi_path_active)
    else $error("spi path inactive while selected");
  a_settle_time: assert property ($changed(spi_path_active) |-> ##[0:1] path_settling [*4] ##[1:3] !path_settling)
    else $error("path settle window wrong");
endmodule // srass_asserts

bind srass_spi_slave srass_asserts #(.ADDR_W(ADDR_W)) u_asserts (
  .core_clk(core_clk), .rst(rst), .spi_sel_n(spi_sel_n), .spi_miso(spi_miso),
  .cfg_wr(cfg_wr), .cfg_in(cfg_in), .cfg_out(cfg_out),
  .multipurpose_io_one(multipurpose_io_one), .spi_path_active(spi_path_active),
  .path_settling(path_settling), .frame_active(frame_active),
  .reg_wr_valid(reg_wr_valid), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data)
);

// file: srass_master.sv
`timescale 1ns/1ps
module srass_master (
  // clocking mode
  input wire logic cpol,
  input wire logic cpha,
  // link pins
  output logic     spi_clk,
  output logic     spi_sel_n,
  output logic     spi_mosi,
  input wire logic spi_miso
);
  logic [7:0] tx_q [$];
  logic [7:0] rx_q [$];

  //==========================================
  // idle state
  initial begin
    spi_clk = 1'b0;
    spi_sel_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // one frame of whole bytes; the last byte stops after last_bits bits
  task automatic run(input int last_bits);
    logic [7:0] r;
    int lim;
    rx_q.delete();
    spi_clk = cpol;                       // clock stands still outside frames
    #15 spi_sel_n = 1'b0;
    #15;
    for (int i = 0; i < tx_q.size(); i++) begin
      lim = (i == tx_q.size() - 1) ? 8 - last_bits : 0;
      for (int k = 7; k >= lim; k--) begin
        if (cpha) spi_clk = ~spi_clk;     // launch edge in phase 1
        spi_mosi = tx_q[i][k];
        #7.5 r = {r[6:0], spi_miso};
        spi_clk = ~spi_clk;               // sample edge, 15 ns period
        #7.5;
        if (!cpha) spi_clk = ~spi_clk;
      end
      if (lim == 0) rx_q.push_back(r);
    end
    #15 spi_sel_n = 1'b1;
    spi_mosi = ~spi_mosi;                 // released line shows no stale bit
    #30;
  endtask
endmodule // srass_master

// file: srass_spi_slave_tb.sv
`timescale 1ns/1ps
module srass_spi_slave_tb;
  //==========================================
  // signals and instances
  logic                  core_clk, rst, spi_clk, spi_sel_n, spi_mosi, spi_miso;
  logic                  cfg_wr, pin_sel, cpol, cpha, path_on, settling, frm, wr_v;
  srass_pkg::srass_cfg_t cfg_in, cfg_out;
  logic [9:0]            wr_a, rd_a;
  logic [7:0]            wr_d, rd_d;
  logic [17:0]           wq [$];
  int                    num_errors, check_count;

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  srass_spi_slave uut (
    .core_clk(core_clk), .rst(rst), .spi_clk(spi_clk), .spi_sel_n(spi_sel_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
    .cfg_out(cfg_out), .multipurpose_io_one(pin_sel), .spi_path_active(path_on),
    .path_settling(settling), .frame_active(frm), .reg_wr_valid(wr_v),
    .reg_wr_addr(wr_a), .reg_wr_data(wr_d), .core_rd_addr(rd_a), .core_rd_data(rd_d)
  );
  srass_master mst (
    .cpol(cpol), .cpha(cpha), .spi_clk(spi_clk), .spi_sel_n(spi_sel_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso)
  );

  // collect write notices, one per committed byte
  always @(posedge core_clk) if (wr_v === 1'b1) wq.push_back({wr_a, wr_d});

  //==========================================
  // helpers
  task automatic check(input logic [17:0] got, input logic [17:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // host waits out the path switch guard before any frame
  task automatic settle();
    repeat (4) @(negedge core_clk);
    for (int i = 0; i < 20 && settling !== 1'b0; i++) @(negedge core_clk);
  endtask

  task automatic set_cfg(input logic [5:0] v);
    cfg_in = v;
    cfg_wr = 1'b1;
    @(negedge core_clk);
    cfg_wr = 1'b0;
    cpol = v[1];
    cpha = v[2];
    settle();
  endtask

  task automatic xfer(input logic [7:0] b [$], input int last_bits);
    wq.delete();
    mst.tx_q = b;
    mst.run(last_bits);
    repeat (10) @(negedge core_clk);
  endtask

  task automatic check_writes(input logic [9:0] a, input logic [7:0] d [$]);
    check(wq.size(), d.size(), "write count");
    foreach (d[i]) check(wq[i], {10'(a + i), d[i]}, "write");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  //==========================================
  // tests
  initial begin
    rst = 1'b1;
    cfg_wr = 1'b0;
    cfg_in = 6'h01;
    pin_sel = 1'b0; // two-wire bus carries no traffic while spi is selected
    rd_a = 10'h000;
    cpol = 1'b0;
    cpha = 1'b0;
    repeat (3) @(negedge core_clk);
    check(cfg_out, 6'h01, "cfg reset");
    check(spi_miso, 1'b0, "miso idle");
    rst = 1'b0;
    settle();
    check(path_on, 1'b1, "path after reset");
    $display("test reset done");
    // counted write crossing a page, extra byte ignored
    xfer('{8'h01, 8'hfe, 8'h03, 8'ha1, 8'ha2, 8'ha3, 8'h55}, 8);
    check_writes(10'h1fe, '{8'ha1, 8'ha2, 8'ha3});
    rd_a = 10'h200;
    @(negedge core_clk);
    check(rd_d, 8'ha3, "core read");
    xfer('{8'h81, 8'hfe, 8'h02, 8'h00, 8'h00, 8'h00}, 8);
    check(mst.rx_q[3], 8'ha1, "read first");
    check(mst.rx_q[4], 8'ha2, "read second");
    check(mst.rx_q[5], 8'h00, "read after count");
    xfer('{8'h40, 8'h05, 8'h01, 8'h66, 8'h77}, 8);
    check_writes(10'h005, '{8'h66});
    $display("test counted done");
    // open bursts without a length byte, partial byte dropped
    set_cfg(6'h00);
    xfer('{8'h40, 8'h10, 8'hb1, 8'hb2, 8'hb3, 8'hff}, 5);
    check_writes(10'h010, '{8'hb1, 8'hb2, 8'hb3});
    xfer('{8'hc0, 8'h10, 8'h00, 8'h00, 8'h00}, 8);
    check(mst.rx_q[4], 8'hb3, "open read");
    xfer('{8'h00, 8'h20, 8'hc1, 8'hc2}, 8);
    check_writes(10'h020, '{8'hc1});
    $display("test open burst done");
    // inverted read/write flag
    set_cfg(6'h09);
    xfer('{8'h80, 8'h40, 8'h01, 8'h5a}, 8);
    check_writes(10'h040, '{8'h5a});
    xfer('{8'h00, 8'h40, 8'h01, 8'h00}, 8);
    check(mst.rx_q[3], 8'h5a, "inverted read");
    $display("test polarity done");
    // all four clocking modes
    for (int m = 0; m < 4; m++) begin
      set_cfg({3'h0, 2'(m), 1'b1});
      xfer('{8'h00, 8'(8'h30 + m), 8'h01, 8'(8'h3c ^ m)}, 8);
      check_writes(10'(10'h030 + m), '{8'(8'h3c ^ m)});
      xfer('{8'h80, 8'(8'h30 + m), 8'h01, 8'h00}, 8);
      check(mst.rx_q[3], 8'(8'h3c ^ m), "mode read");
    end
    $display("test modes done");
    // path off by pin mode, then by the select pin held high
    set_cfg(6'h11);
    check(path_on, 1'b0, "pin mode off");
    xfer('{8'h00, 8'h50, 8'h01, 8'h99}, 8);
    check(wq.size(), 0, "refused write");
    set_cfg(6'h01);
    pin_sel = 1'b1; // two-wire selected, pin held high throughout
    settle();
    check(path_on, 1'b0, "pin high");
    xfer('{8'h80, 8'h40, 8'h01, 8'h00}, 8);
    check(mst.rx_q[3], 8'h00, "refused read");
    pin_sel = 1'b0;
    settle();
    check(path_on, 1'b1, "pin low");
    $display("test path done");
    end_of_test();
  end

  // watchdog: the tests need roughly 14 us
  initial begin
    #200000;
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule // srass_spi_slave_tb
